// file: sim/pcv_host_model.sv
`timescale 1ns/10ps
module pcv_host_model (
    // clock and lines seen by the initiator
    input wire logic        clock,
    input wire logic        devsel_n,
    input wire logic        trdy_n,
    input wire logic [31:0] ad_in,
    // initiator lines
    output logic            frame_n,
    output logic            irdy_n,
    output logic            idsel,
    output logic [3:0]      cbe_n,
    output logic [31:0]     ad,
    // one-cycle outcome: claimed, devsel edge count, read data
    output logic            done,
    output logic [35:0]     result
);
    initial begin
        frame_n = 1'b1;
        irdy_n = 1'b1;
        idsel = 1'b0;
        cbe_n = 4'h0;
        ad = 32'h0;
        done = 1'b0;
        result = 36'h0;
    end

    // single data phase; master abort when nobody claims within eight edges
    task automatic xfer(input logic [3:0] cmd, input logic sel, input logic [31:0] a,
                        input logic [31:0] wd);
        int         n;
        logic [2:0] lat;
        logic       got;
        lat = 3'h0;
        got = 1'b0;
        @(posedge clock);
        frame_n <= 1'b0;
        idsel <= sel;
        cbe_n <= cmd;
        ad <= a;
        @(posedge clock);
        frame_n <= 1'b1;
        irdy_n <= 1'b0;
        idsel <= 1'b0;
        cbe_n <= 4'h0;
        ad <= cmd[0] ? wd : ~a; // on reads the lines are not ours, so they keep moving
        for (n = 2; n < 9 && !got; n++) begin
            @(posedge clock);
            if (!devsel_n && lat == 3'h0) lat = n[2:0];
            if (!trdy_n && !devsel_n) got = 1'b1;
        end
        result <= got ? {1'b1, lat, cmd[0] ? 32'h0 : ad_in} : 36'h0;
        done <= 1'b1;
        irdy_n <= 1'b1;
        ad <= ~ad;
        @(posedge clock);
        done <= 1'b0;
        ad <= ~ad;
        repeat (3) @(posedge clock);
    endtask
endmodule

// file: sim/pcv_target_props.sv
`timescale 1ns/10ps
module pcv_target_props (
    // clock and reset
    input wire logic                      clock,
    input wire logic                      rst_n,
    input wire logic                      ce,
    // bus pins
    input wire pcv_pkg::pcv_bus_in_type   bus_in,
    input wire pcv_pkg::pcv_bus_out_type  bus_out,
    // core side
    input wire logic                      io_hit,
    input wire logic                      mem_hit,
    input wire logic                      palette_hit,
    input wire pcv_pkg::pcv_core_req_type core_req,
    input wire logic                      core_ack,
    input wire logic [31:0]               core_rdata,
    input wire logic                      io_enable,
    input wire logic                      mem_enable,
    input wire logic                      snoop_enable
);
    default clocking cb @(posedge clock);
    endclocking
    // a frozen block answers nothing, so attempts that see ce low are dropped
    default disable iff (!rst_n || !ce);

    // decode helpers; released control lines count as high
    wire       cfg_a = bus_in.idsel && bus_in.cbe_n[3:1] == 3'h5 && bus_in.ad[1:0] == 2'h0;
    wire       quiet = bus_out.devsel_n || !bus_out.ctl_oe;
    wire       fin   = !bus_out.trdy_n && !bus_in.irdy_n && bus_out.ctl_oe;
    wire [2:0] bits  = {io_enable, mem_enable, snoop_enable};

    chk_cfg_claim: assert property ($fell(bus_in.frame_n) && cfg_a && bus_in.ad[10:9] == 2'h0
        |-> ##2 !bus_out.devsel_n && bus_out.ctl_oe) else $error("config cycle not claimed");
    chk_func_ignored: assert property ($fell(bus_in.frame_n) && cfg_a && bus_in.ad[10:9] != 2'h0
        |-> quiet[*5]) else $error("high function claimed");
    chk_mem_off: assert property ($fell(bus_in.frame_n) && bus_in.cbe_n[3:1] == 3'h3
        && !mem_enable |-> quiet[*5]) else $error("memory cycle claimed while off");
    chk_io_claim: assert property ($fell(bus_in.frame_n) && bus_in.cbe_n == 4'h2 && io_hit
        && io_enable |-> ##2 !bus_out.devsel_n) else $error("io read not claimed in time");
    chk_snoop_skip: assert property ($fell(bus_in.frame_n) && bus_in.cbe_n == 4'h3
        && palette_hit && snoop_enable |-> quiet[*5]) else $error("palette write claimed");
    chk_mem_req: assert property ($fell(bus_in.frame_n) && bus_in.cbe_n == 4'h7 && mem_hit
        && mem_enable |=> core_req.req && core_req.write) else $error("core write not requested");
    chk_reset_quiet: assert property ($rose(rst_n)
        |-> !bus_out.ctl_oe && !bus_out.ad_oe && bits == 3'h0) else $error("not quiet after reset");
    chk_bits_cause: assert property ($changed(bits)
        |-> $past(fin, 1) || $past(fin, 2) || $past(fin, 3)) else $error("command bits moved alone");
    chk_turn_release: assert property ($rose(bus_out.devsel_n) && bus_out.ctl_oe
        |=> !bus_out.ctl_oe) else $error("control lines not released");

    chk_core_wdata: assert property (fin && core_req.req && core_req.write
        |=> core_req.wstrobe && core_req.wdata == $past(bus_in.ad)) else $error("no wstrobe");
    chk_par_trail: assert property (bus_out.ad_oe |=> bus_out.par_oe
        && bus_out.par == ^{$past(bus_out.ad), $past(bus_in.cbe_n)}) else $error("parity wrong");

    cov_cfg: cover property ($fell(bus_in.frame_n) && cfg_a);
    cov_abort: cover property ($fell(bus_in.frame_n) ##1 quiet[*5]);
    cov_bits: cover property ($changed(bits));
endmodule

// file: sim/pcv_target_tb.sv
`timescale 1ns/10ps
module pcv_target_tb;
    // arbitrary identity values
    localparam logic [12:0] CHIP  = 13'h0c31;
    localparam logic [15:0] MAKER = 16'h5a17;
    localparam logic [7:0]  REV   = 8'h2e;
    logic                      clock;
    logic                      rst_n;
    logic                      io_hit;
    logic                      mem_hit;
    logic                      palette_hit;
    logic                      core_ack;
    logic                      slow_core;
    logic                      ce;
    logic [31:0]               core_rdata;
    logic [31:0]               seed = 32'hdbb380bb;
    logic [31:0]               d;
    logic [3:0]                mcmd [5] = '{4'h6, 4'h7, 4'hc, 4'he, 4'hf};
    pcv_pkg::pcv_bus_in_type   bus_in;
    pcv_pkg::pcv_bus_out_type  bus_out;
    pcv_pkg::pcv_core_req_type core_req;
    logic                      io_enable;
    logic                      mem_enable;
    logic                      snoop_enable;
    logic                      frame_n;
    logic                      irdy_n;
    logic                      idsel;
    logic [3:0]                cbe_n;
    logic [31:0]               h_ad;
    logic                      done;
    logic [35:0]               result;
    logic [35:0]               exp_q[$];
    int                        bad_count = 0;
    int                        checks_done = 0;

    initial begin
        clock = 1'b0;
        forever #20 clock = ~clock;
    end

    // shared address/data wire: the target wins while it drives
    assign bus_in = {frame_n, irdy_n, idsel, cbe_n, bus_out.ad_oe ? bus_out.ad : h_ad};

    pcv_target #(.CHIP_NUMBER(CHIP), .MAKER_CODE(MAKER), .REVISION(REV)) i_dut (
        .clock(clock), .rst_n(rst_n), .ce(ce), .bus_in(bus_in), .bus_out(bus_out),
        .io_hit(io_hit), .mem_hit(mem_hit), .palette_hit(palette_hit), .core_req(core_req),
        .core_ack(core_ack), .core_rdata(core_rdata), .io_enable(io_enable),
        .mem_enable(mem_enable), .snoop_enable(snoop_enable));

    // released control lines are pulled high
    pcv_host_model i_host (
        .clock(clock), .devsel_n(bus_out.devsel_n | !bus_out.ctl_oe),
        .trdy_n(bus_out.trdy_n | !bus_out.ctl_oe), .ad_in(bus_in.ad), .frame_n(frame_n),
        .irdy_n(irdy_n), .idsel(idsel), .cbe_n(cbe_n), .ad(h_ad), .done(done), .result(result));

    function automatic logic [31:0] rnd();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction

    function automatic logic [31:0] ca(input logic [2:0] fn, input logic [5:0] idx);
        return {21'h0, fn, idx, 2'h0};
    endfunction

    // claimed outcome: devsel on the third edge after the address, then the data
    function automatic logic [35:0] hit(input logic [31:0] v);
        return {1'b1, 3'h3, v};
    endfunction

    task automatic check(input logic [35:0] seen, input logic [35:0] want);
        checks_done++;
        if (seen !== want) begin
            bad_count++;
            $display("CHECK FAILED %0t got %h want %h", $time, seen, want);
        end
    endtask

    task automatic op(input logic [3:0] cmd, input logic [31:0] a, input logic [31:0] wd,
                      input logic [35:0] want);
        exp_q.push_back(want);
        i_host.xfer(cmd, cmd[3:1] == 3'h5, a, wd);
    endtask

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", checks_done, bad_count);
        if (bad_count == 0 && checks_done > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // each finished transfer is matched against the oldest note
    always @(posedge clock) begin
        if (done === 1'b1) begin
            if (exp_q.size() == 0) bad_count++;
            else check(result, exp_q.pop_front());
        end
    end

    // stand-in core: ready at once, or a clock after its request when slow
    always @(posedge clock) begin
        core_ack <= slow_core ? core_req.req : 1'b1;
    end

    initial begin
        repeat (20000) @(posedge clock);
        bad_count++;
        $display("CHECK FAILED %0t run hung", $time);
        test_done();
    end

    initial begin
        rst_n = 1'b0;
        io_hit = 1'b0;
        mem_hit = 1'b0;
        palette_hit = 1'b0;
        slow_core = 1'b0;
        ce = 1'b1;
        core_rdata = 32'h0;
        repeat (4) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check({33'h0, io_enable, mem_enable, snoop_enable}, 36'h0);
        // identity and base address registers are written first to show writes are ignored
        for (int f = 0; f < 2; f++) begin
            op(4'hb, ca(f[2:0], 6'h0), rnd(), hit(32'h0));
            op(4'ha, ca(f[2:0], 6'h0), 32'h0, hit({CHIP, f[2:0], MAKER}));
            op(4'ha, ca(f[2:0], 6'h3), 32'h0, hit(32'h0080_0000));
        end
        op(4'ha, ca(3'h0, 6'h1), 32'h0, hit(32'h0200_0000));
        op(4'ha, ca(3'h0, 6'h2), 32'h0, hit({24'h030000, REV}));
        for (int i = 4; i < 10; i++) begin
            op(4'hb, ca(3'h0, i[5:0]), rnd(), hit(32'h0));
            op(4'ha, ca(3'h0, i[5:0]), 32'h0, hit(32'h0));
        end
        op(4'ha, ca(3'h0, 6'h3f), 32'h0, hit(32'h0));
        $display("test fixed registers done");
        for (int f = 2; f < 8; f++) begin
            op(4'ha, ca(f[2:0], 6'h0), 32'h0, 36'h0);
        end
        op(4'ha, ca(3'h0, 6'h0) | 32'h1, 32'h0, 36'h0);
        $display("test unclaimed cycles done");
        // random reserved bits with all three enables set
        d = rnd() | 32'h23;
        op(4'hb, ca(3'h0, 6'h1), d, hit(32'h0));
        op(4'hb, ca(3'h1, 6'h1), 32'h0, hit(32'h0));
        op(4'ha, ca(3'h0, 6'h1), 32'h0, hit(32'h0200_0023));
        check({33'h0, io_enable, mem_enable, snoop_enable}, {33'h0, 3'h7});
        mem_hit <= 1'b1;
        for (int k = 0; k < 5; k++) begin
            d = rnd();
            slow_core <= k[0];
            core_rdata <= d;
            op(mcmd[k], d & 32'hffff_fffc, d, hit(mcmd[k][0] ? 32'h0 : d));
        end
        mem_hit <= 1'b0;
        io_hit <= 1'b1;
        op(4'h2, 32'h3c4, 32'h0, hit(d));
        palette_hit <= 1'b1;
        op(4'h3, 32'h3c9, rnd(), 36'h0);
        palette_hit <= 1'b0;
        op(4'h3, 32'h3c9, rnd(), hit(32'h0));
        $display("test enabled spaces done");
        op(4'hb, ca(3'h0, 6'h1), 32'h0, hit(32'h0));
        check({33'h0, io_enable, mem_enable, snoop_enable}, 36'h0);
        op(4'h2, 32'h3c4, 32'h0, 36'h0);
        mem_hit <= 1'b1;
        op(4'h7, 32'h100, rnd(), 36'h0);
        $display("test disabled spaces done");
        // set bits must clear on a mid-run reset and stay clear through a write while ce is low
        op(4'hb, ca(3'h0, 6'h1), 32'h23, hit(32'h0));
        rst_n <= 1'b0;
        repeat (2) @(posedge clock);
        rst_n <= 1'b1;
        @(posedge clock);
        check({33'h0, io_enable, mem_enable, snoop_enable}, 36'h0);
        ce <= 1'b0;
        op(4'hb, ca(3'h0, 6'h1), 32'h23, 36'h0);
        ce <= 1'b1;
        check({33'h0, io_enable, mem_enable, snoop_enable}, 36'h0);
        $display("test reset and clock enable done");
        if (exp_q.size() != 0) bad_count++;
        test_done();
    end
endmodule

bind pcv_target pcv_target_props i_props (
    .clock(clock), .rst_n(rst_n), .ce(ce), .bus_in(bus_in), .bus_out(bus_out), .io_hit(io_hit),
    .mem_hit(mem_hit), .palette_hit(palette_hit), .core_req(core_req), .core_ack(core_ack),
    .core_rdata(core_rdata), .io_enable(io_enable), .mem_enable(mem_enable),
    .snoop_enable(snoop_enable));

// file: src/pcv_cfg_regs.sv
`timescale 1ns/10ps
module pcv_cfg_regs #(
    parameter logic [12:0] CHIP_NUMBER = 13'h0a5,  // arbitrary value
    parameter logic [15:0] MAKER_CODE  = 16'h1d5c, // arbitrary value
    parameter logic [7:0]  REVISION    = 8'h00     // arbitrary value
) (
    // clock and reset
    input  wire logic                   clock,
    input  wire logic                   rst_n,
    input  wire logic                   ce,
    // write and read access
    input  wire pcv_pkg::pcv_cfg_wr_type wr,
    input  wire logic [2:0]             rd_func,
    input  wire logic [5:0]             rd_idx,
    output logic [31:0]                 rd_data,
    // command bits
    output logic                        io_enable,
    output logic                        mem_enable,
    output logic                        snoop_enable
);

    logic next_io_enable;
    logic next_mem_enable;
    logic next_snoop_enable;
    logic cmd_write;

    // only function zero owns a command register; byte lane 0 carries its bits
    assign cmd_write = wr.strobe && wr.func == 3'h0 && wr.idx == pcv_pkg::IDX_CMD_STATUS
                       && !wr.be_n[0];

    // writable command bits; every other bit in the space ignores writes
    always_comb begin
        next_io_enable    = io_enable;
        next_mem_enable   = mem_enable;
        next_snoop_enable = snoop_enable;
        if (!rst_n) begin
            next_io_enable    = pcv_pkg::CMD_RESET_BIT;
            next_mem_enable   = pcv_pkg::CMD_RESET_BIT;
            next_snoop_enable = pcv_pkg::CMD_RESET_BIT;
        end else if (cmd_write) begin
            next_io_enable    = wr.wdata[pcv_pkg::CMD_IO_BIT];
            next_mem_enable   = wr.wdata[pcv_pkg::CMD_MEM_BIT];
            next_snoop_enable = wr.wdata[pcv_pkg::CMD_SNOOP_BIT];
        end
    end

    always_ff @(posedge clock) begin
        if (ce) begin
            io_enable    <= next_io_enable;
            mem_enable   <= next_mem_enable;
            snoop_enable <= next_snoop_enable;
        end
    end

    // read mux: constant fields are wired, so nothing indeterminate needs a reset
    always_comb begin
        rd_data = 32'h00000000;
        case (rd_idx)
            pcv_pkg::IDX_IDENTITY: begin
                rd_data = {CHIP_NUMBER, rd_func, MAKER_CODE};
            end
            pcv_pkg::IDX_CMD_STATUS: begin
                if (rd_func == 3'h0) begin
                    rd_data[26:25] = pcv_pkg::SPEED_MEDIUM;
                    rd_data[pcv_pkg::CMD_SNOOP_BIT] = snoop_enable;
                    rd_data[pcv_pkg::CMD_MEM_BIT]   = mem_enable;
                    rd_data[pcv_pkg::CMD_IO_BIT]    = io_enable;
                end
            end
            pcv_pkg::IDX_CLASS_REV: begin
                if (rd_func == 3'h0) begin
                    rd_data = {pcv_pkg::CLASS_VGA, REVISION};
                end
            end
            pcv_pkg::IDX_HEADER: begin
                rd_data[23:16] = pcv_pkg::HEADER_MULTI;
            end
            default: begin
                rd_data = 32'h00000000;
            end
        endcase
    end

endmodule

// file: src/pcv_pkg.sv
// Operation
// - each implemented function exposes a 256-byte configuration space
// - configuration accesses to the first 512 bytes (two functions) are claimed
// - configuration accesses to functions two to seven are never claimed
// - identity bits 31:19 return the read-only chip number
// - identity bits 18:16 return the function number from address bits 10:8
// - identity bits 15:0 return the read-only maker code
// - status bits 26:25 read 01, medium decode speed; function one reads them as 00
// - non-configuration accesses are claimed with medium decode timing
// - command bit 5 enables palette snooping, resets to 0
// - command bit 1 enables memory-space response, resets to 0
// - command bit 0 enables I/O-space response
// - indeterminate fields are not reset; non-writable fields ignore writes
// - header-type byte reads 0x80, multi-function device
// - function zero reports class code 0x030000
// - base address registers read zero and ignore writes
package pcv_pkg;

    // configuration space geometry
    localparam int          CFG_SPACE_BYTES = 256;
    localparam int          FUNC_COUNT      = 2;
    localparam int          REG_IDX_W       = 6;

    // register word indices inside one function (byte offset / 4)
    localparam logic [5:0]  IDX_IDENTITY    = 6'h00;
    localparam logic [5:0]  IDX_CMD_STATUS  = 6'h01;
    localparam logic [5:0]  IDX_CLASS_REV   = 6'h02;
    localparam logic [5:0]  IDX_HEADER      = 6'h03;
    localparam logic [5:0]  IDX_BAR_FIRST   = 6'h04;
    localparam logic [5:0]  IDX_BAR_LAST    = 6'h09;

    // field positions and fixed values
    localparam int          CMD_IO_BIT      = 0;
    localparam int          CMD_MEM_BIT     = 1;
    localparam int          CMD_SNOOP_BIT   = 5;
    localparam logic [1:0]  SPEED_MEDIUM    = 2'h1;
    localparam logic [7:0]  HEADER_MULTI    = 8'h80;
    localparam logic [23:0] CLASS_VGA       = 24'h030000;
    localparam logic        CMD_RESET_BIT   = 1'h0;

    // bus command codes as seen on the command/byte-enable lines
    localparam logic [3:0]  BC_IO_RD        = 4'h2;
    localparam logic [3:0]  BC_IO_WR        = 4'h3;
    localparam logic [3:0]  BC_MEM_RD       = 4'h6;
    localparam logic [3:0]  BC_MEM_WR       = 4'h7;
    localparam logic [3:0]  BC_CFG_RD       = 4'ha;
    localparam logic [3:0]  BC_CFG_WR       = 4'hb;
    localparam logic [3:0]  BC_MEM_RD_MULT  = 4'hc;
    localparam logic [3:0]  BC_MEM_RD_LINE  = 4'he;
    localparam logic [3:0]  BC_MEM_WR_INV   = 4'hf;

    typedef enum logic [2:0] {
        ST_IDLE   = 3'b000,
        ST_DECODE = 3'b001,
        ST_DATA   = 3'b010,
        ST_TURN   = 3'b011
    } pcv_state_type;

    // bus pins sampled by the target
    typedef struct packed {
        logic        frame_n;
        logic        irdy_n;
        logic        idsel;
        logic [3:0]  cbe_n;
        logic [31:0] ad;
    } pcv_bus_in_type;

    // bus pins driven by the target, each with its enable
    typedef struct packed {
        logic [31:0] ad;
        logic        ad_oe;
        logic        par;
        logic        par_oe;
        logic        devsel_n;
        logic        trdy_n;
        logic        stop_n;
        logic        ctl_oe;
    } pcv_bus_out_type;

    // request toward the accelerator core for claimed non-configuration cycles
    typedef struct packed {
        logic        req;
        logic        write;
        logic [31:0] addr;
        logic        wstrobe;
        logic [31:0] wdata;
        logic [3:0]  be_n;
    } pcv_core_req_type;

    // configuration register write request
    typedef struct packed {
        logic        strobe;
        logic [2:0]  func;
        logic [5:0]  idx;
        logic [31:0] wdata;
        logic [3:0]  be_n;
    } pcv_cfg_wr_type;

endpackage

// file: src/pcv_target.sv
`timescale 1ns/10ps
module pcv_target #(
    parameter logic [12:0] CHIP_NUMBER = 13'h0a5,  // arbitrary value
    parameter logic [15:0] MAKER_CODE  = 16'h1d5c, // arbitrary value
    parameter logic [7:0]  REVISION    = 8'h00     // arbitrary value
) (
    // clock and reset
    input  wire logic                      clock,
    input  wire logic                      rst_n,
    input  wire logic                      ce,
    // bus pins
    input  wire pcv_pkg::pcv_bus_in_type   bus_in,
    output pcv_pkg::pcv_bus_out_type       bus_out,
    // address decoders of the accelerator core
    input  wire logic                      io_hit,
    input  wire logic                      mem_hit,
    input  wire logic                      palette_hit,
    // core data path
    output pcv_pkg::pcv_core_req_type      core_req,
    input  wire logic                      core_ack,
    input  wire logic [31:0]               core_rdata,
    // command bits seen by the core
    output logic                           io_enable,
    output logic                           mem_enable,
    output logic                           snoop_enable
);

    pcv_pkg::pcv_state_type    state;
    pcv_pkg::pcv_state_type    next_state;
    pcv_pkg::pcv_bus_out_type  next_bus_out;
    pcv_pkg::pcv_core_req_type next_core_req;
    pcv_pkg::pcv_cfg_wr_type   cfg_wr;
    pcv_pkg::pcv_cfg_wr_type   next_cfg_wr;
    logic                      frame_q;
    logic                      is_cfg;
    logic                      next_is_cfg;
    logic                      is_write;
    logic                      next_is_write;
    logic [2:0]                cfg_func;
    logic [2:0]                next_cfg_func;
    logic [5:0]                cfg_idx;
    logic [5:0]                next_cfg_idx;
    logic [31:0]               cfg_rdata;

    // address-phase decode
    logic [3:0] cmd;
    logic       addr_phase;
    logic       cfg_claim;
    logic       io_cmd;
    logic       mem_cmd;
    logic       io_claim;
    logic       mem_claim;
    logic       done;
    logic       gone;

    assign cmd        = bus_in.cbe_n;
    assign addr_phase = !bus_in.frame_n && frame_q;
    // only type-0 cycles to the two implemented functions are claimed
    assign cfg_claim  = bus_in.idsel && (cmd == pcv_pkg::BC_CFG_RD || cmd == pcv_pkg::BC_CFG_WR)
                        && bus_in.ad[1:0] == 2'h0
                        && bus_in.ad[10:8] < 3'(pcv_pkg::FUNC_COUNT);
    assign io_cmd     = cmd == pcv_pkg::BC_IO_RD || cmd == pcv_pkg::BC_IO_WR;
    assign mem_cmd    = cmd == pcv_pkg::BC_MEM_RD || cmd == pcv_pkg::BC_MEM_WR
                        || cmd == pcv_pkg::BC_MEM_RD_MULT || cmd == pcv_pkg::BC_MEM_RD_LINE
                        || cmd == pcv_pkg::BC_MEM_WR_INV;
    // a snooped palette write is left for the owning agent to claim
    assign io_claim   = io_cmd && io_hit && io_enable
                        && !(snoop_enable && cmd == pcv_pkg::BC_IO_WR && palette_hit);
    assign mem_claim  = mem_cmd && mem_hit && mem_enable;
    assign done       = !bus_out.trdy_n && !bus_in.irdy_n;
    assign gone       = bus_in.frame_n && bus_in.irdy_n; // master gave up

    // configuration registers of both functions
    pcv_cfg_regs #(
        .CHIP_NUMBER (CHIP_NUMBER),
        .MAKER_CODE  (MAKER_CODE),
        .REVISION    (REVISION)
    ) u_regs (
        .clock        (clock),
        .rst_n        (rst_n),
        .ce           (ce),
        .wr           (cfg_wr),
        .rd_func      (cfg_func),
        .rd_idx       (cfg_idx),
        .rd_data      (cfg_rdata),
        .io_enable    (io_enable),
        .mem_enable   (mem_enable),
        .snoop_enable (snoop_enable)
    );

    // target sequencer: idle, decode wait, data phase, turnaround
    always_comb begin
        next_state            = state;
        next_bus_out          = bus_out;
        next_core_req         = core_req;
        next_cfg_wr           = cfg_wr;
        next_is_cfg           = is_cfg;
        next_is_write         = is_write;
        next_cfg_func         = cfg_func;
        next_cfg_idx          = cfg_idx;
        next_cfg_wr.strobe    = 1'b0;
        next_core_req.wstrobe = 1'b0;
        // parity trails the driven data by one clock
        next_bus_out.par      = ^{bus_out.ad, bus_in.cbe_n};
        next_bus_out.par_oe   = bus_out.ad_oe;
        case (state)
            pcv_pkg::ST_IDLE: begin
                next_bus_out.ctl_oe = 1'b0;
                next_bus_out.ad_oe  = 1'b0;
                if (addr_phase && (cfg_claim || io_claim || mem_claim)) begin
                    next_state    = pcv_pkg::ST_DECODE;
                    next_is_cfg   = cfg_claim;
                    next_is_write = cmd[0];
                    next_cfg_func = bus_in.ad[10:8];
                    // word index inside the 256-byte space
                    next_cfg_idx  = bus_in.ad[7:2];
                    next_core_req.req   = !cfg_claim;
                    next_core_req.write = cmd[0];
                    next_core_req.addr  = bus_in.ad;
                end
            end
            pcv_pkg::ST_DECODE: begin
                // devsel shows on the second clock after the address: medium speed
                next_state            = pcv_pkg::ST_DATA;
                next_bus_out.ctl_oe   = 1'b1;
                next_bus_out.devsel_n = 1'b0;
                next_bus_out.ad_oe    = !is_write;
                next_bus_out.ad       = is_cfg ? cfg_rdata : core_rdata;
                // configuration and core writes are taken at once; core reads wait
                next_bus_out.trdy_n   = !(is_cfg || is_write || core_ack);
                next_bus_out.stop_n   = next_bus_out.trdy_n;
            end
            pcv_pkg::ST_DATA: begin
                if (done || gone) begin
                    // single data phase; stop with trdy disconnects any burst
                    next_state            = pcv_pkg::ST_TURN;
                    next_bus_out.devsel_n = 1'b1;
                    next_bus_out.trdy_n   = 1'b1;
                    next_bus_out.stop_n   = 1'b1;
                    next_bus_out.ad_oe    = 1'b0;
                    next_core_req.req     = 1'b0;
                    if (done && is_write && is_cfg) begin
                        next_cfg_wr.strobe = 1'b1;
                        next_cfg_wr.func   = cfg_func;
                        next_cfg_wr.idx    = cfg_idx;
                        next_cfg_wr.wdata  = bus_in.ad;
                        next_cfg_wr.be_n   = bus_in.cbe_n;
                    end
                    if (done && is_write && !is_cfg) begin
                        next_core_req.wstrobe = 1'b1;
                        next_core_req.wdata   = bus_in.ad;
                        next_core_req.be_n    = bus_in.cbe_n;
                    end
                end else if (!is_cfg && !is_write && bus_out.trdy_n) begin
                    next_bus_out.ad     = core_rdata;
                    next_bus_out.trdy_n = !core_ack;
                    next_bus_out.stop_n = !core_ack;
                end
            end
            pcv_pkg::ST_TURN: begin
                // control lines driven high one clock before release
                next_state          = pcv_pkg::ST_IDLE;
                next_bus_out.ctl_oe = 1'b0;
            end
            default: begin
                next_state = pcv_pkg::ST_IDLE;
            end
        endcase
        if (!rst_n) begin
            next_state            = pcv_pkg::ST_IDLE;
            next_bus_out          = '0;
            next_bus_out.devsel_n = 1'b1;
            next_bus_out.trdy_n   = 1'b1;
            next_bus_out.stop_n   = 1'b1;
            next_core_req         = '0;
            next_cfg_wr           = '0;
            next_is_cfg           = 1'b0;
            next_is_write         = 1'b0;
            next_cfg_func         = 3'h0;
            next_cfg_idx          = 6'h00;
        end
    end

    // frame history lets a new address phase be seen only after idle
    always_ff @(posedge clock) begin
        if (ce) begin
            frame_q  <= rst_n ? bus_in.frame_n : 1'b1;
            state    <= next_state;
            bus_out  <= next_bus_out;
            core_req <= next_core_req;
            cfg_wr   <= next_cfg_wr;
            is_cfg   <= next_is_cfg;
            is_write <= next_is_write;
            cfg_func <= next_cfg_func;
            cfg_idx  <= next_cfg_idx;
        end
    end

endmodule
